// ==== hdl/fsp_regs.vh ====
`ifndef FSP_REGS_VH
`define FSP_REGS_VH

// ****************************************************************
// Bus timing in nanoseconds and derived clock counts (10 ns clock)
// ****************************************************************
`define FSP_CLK_NS        10
`define FSP_ACCESS_NS     70
`define FSP_ACCESS_CYC    ((`FSP_ACCESS_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_WRITE_NS      50
`define FSP_WRITE_CYC     ((`FSP_WRITE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_SETUP_NS      10
`define FSP_SETUP_CYC     ((`FSP_SETUP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

// ****************************************************************
// Address space and command codes
// ****************************************************************
`define FSP_ADDR_W        19
`define FSP_RAM_LIMIT     19'h2_0000
`define FSP_UNLOCK_A1     19'h0_5555
`define FSP_UNLOCK_A2     19'h0_2AAA
`define FSP_UNLOCK_D1     8'hAA
`define FSP_UNLOCK_D2     8'h55
`define FSP_CMD_PROGRAM   8'hA0
`define FSP_CMD_ERASE     8'h80
`define FSP_CMD_SECTOR    8'h30
`define FSP_CMD_BANK      8'h10
`define FSP_SECTOR_LSB    12

// Host request opcodes.
`define FSP_OP_RAM_RD     3'h0
`define FSP_OP_RAM_WR     3'h1
`define FSP_OP_FL_RD      3'h2
`define FSP_OP_FL_PROG    3'h3
`define FSP_OP_FL_SECTOR  3'h4
`define FSP_OP_FL_BANK    3'h5

`endif

// ==== hdl/fsp_host.v ====
`timescale 1ns/1ns
`include "fsp_regs.vh"

module fsp_host #(
  parameter AW = `FSP_ADDR_W,
  parameter DW = 8
) (
  input  wire          i_ref_clk,
  input  wire          i_rst,
  input  wire          i_req,
  input  wire [2:0]    i_op,
  input  wire [AW-1:0] i_addr,
  input  wire [DW-1:0] i_wdata,
  output reg           o_busy,
  output reg           o_done,
  output reg           o_err,
  output reg  [DW-1:0] o_rdata,
  output reg           o_flash_busy,
  output reg  [AW-1:0] o_addr,
  output reg           o_write_strobe_n,
  output reg           o_gate_n,
  output reg           o_ram_bank_select_n,
  output reg           o_flash_bank_select_n,
  output reg  [DW-1:0] o_dq,
  output reg           o_dq_oe,
  input  wire [DW-1:0] i_dq
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam ST_IDLE  = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_WSTRB = 3'd2;
  localparam ST_WHOLD = 3'd3;
  localparam ST_READ  = 3'd4;
  localparam ST_POLL  = 3'd5;
  localparam ST_GAP   = 3'd6;

  localparam integer ACC_CYC = `FSP_ACCESS_CYC;
  localparam integer WR_CYC  = `FSP_WRITE_CYC;
  localparam integer SU_CYC  = `FSP_SETUP_CYC;

  reg [2:0]    state;
  reg [2:0]    op;
  reg [AW-1:0] addr;
  reg [DW-1:0] wdata;
  reg [2:0]    step;
  reg [2:0]    nsteps;
  reg [3:0]    cnt;
  reg          is_flash;
  reg          polling;
  reg          have_prev;
  reg [DW-1:0] prev;
  reg [AW-1:0] poll_addr;
  reg          poll_prog;
  reg          poll_bit;

  // Command byte for one step of a flash sequence.
  reg [AW-1:0] cmd_addr;
  reg [DW-1:0] cmd_data;
  always @* begin
    cmd_addr = `FSP_UNLOCK_A1;
    cmd_data = `FSP_UNLOCK_D1;
    case (step)
      3'd0: begin
        cmd_addr = `FSP_UNLOCK_A1;
        cmd_data = `FSP_UNLOCK_D1;
      end
      3'd1, 3'd4: begin
        cmd_addr = `FSP_UNLOCK_A2;
        cmd_data = `FSP_UNLOCK_D2;
      end
      3'd2: begin
        cmd_addr = `FSP_UNLOCK_A1;
        cmd_data = (op == `FSP_OP_FL_PROG) ? `FSP_CMD_PROGRAM
                                           : `FSP_CMD_ERASE;
      end
      3'd3: begin
        if (op == `FSP_OP_FL_PROG) begin
          cmd_addr = addr;
          cmd_data = wdata;
        end else begin
          cmd_addr = `FSP_UNLOCK_A1;
          cmd_data = `FSP_UNLOCK_D1;
        end
      end
      3'd5: begin
        if (op == `FSP_OP_FL_SECTOR) begin
          cmd_addr = {addr[AW-1:`FSP_SECTOR_LSB],
                      {`FSP_SECTOR_LSB{1'b0}}};
          cmd_data = `FSP_CMD_SECTOR;
        end else begin
          cmd_addr = `FSP_UNLOCK_A1;
          cmd_data = `FSP_CMD_BANK;
        end
      end
      default: begin
        cmd_addr = `FSP_UNLOCK_A1;
        cmd_data = `FSP_UNLOCK_D1;
      end
    endcase
  end

  wire req_ram   = (i_op == `FSP_OP_RAM_RD) || (i_op == `FSP_OP_RAM_WR);
  wire req_erase = (i_op == `FSP_OP_FL_SECTOR) || (i_op == `FSP_OP_FL_BANK);
  wire bad_req   = (i_op > `FSP_OP_FL_BANK) ||
                   (req_ram && (i_addr >= `FSP_RAM_LIMIT)) ||
                   (!req_ram && o_flash_busy);

  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state                 <= ST_IDLE;
      op                    <= 3'h0;
      addr                  <= {AW{1'b0}};
      wdata                 <= {DW{1'b0}};
      step                  <= 3'd0;
      nsteps                <= 3'd0;
      cnt                   <= 4'd0;
      is_flash              <= 1'b0;
      polling               <= 1'b0;
      have_prev             <= 1'b0;
      prev                  <= {DW{1'b0}};
      poll_addr             <= {AW{1'b0}};
      poll_prog             <= 1'b0;
      poll_bit              <= 1'b0;
      o_busy                <= 1'b0;
      o_done                <= 1'b0;
      o_err                 <= 1'b0;
      o_rdata               <= {DW{1'b0}};
      o_flash_busy          <= 1'b0;
      o_addr                <= {AW{1'b0}};
      o_write_strobe_n      <= 1'b1;
      o_gate_n              <= 1'b1;
      o_ram_bank_select_n   <= 1'b1;
      o_flash_bank_select_n <= 1'b1;
      o_dq                  <= {DW{1'b0}};
      o_dq_oe               <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_err  <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Standby: both selects high, gate high, bus released.
          o_ram_bank_select_n   <= 1'b1;
          o_flash_bank_select_n <= 1'b1;
          o_gate_n              <= 1'b1;
          o_write_strobe_n      <= 1'b1;
          o_dq_oe               <= 1'b0;
          if (o_flash_busy) begin
            // Background poll fills idle time; RAM requests still win.
            if (i_req && !bad_req && req_ram) begin
              o_busy <= 1'b1;
              op     <= i_op;
              addr   <= i_addr;
              wdata  <= i_wdata;
              state  <= ST_SETUP;
              cnt    <= 4'd0;
              is_flash <= 1'b0;
              polling  <= 1'b0;
            end else begin
              if (i_req)
                o_err <= 1'b1;
              polling  <= 1'b1;
              is_flash <= 1'b1;
              state    <= ST_SETUP;
              cnt      <= 4'd0;
            end
          end else if (i_req) begin
            if (bad_req) begin
              o_err <= 1'b1;
            end else begin
              o_busy   <= 1'b1;
              op       <= i_op;
              addr     <= i_addr;
              wdata    <= i_wdata;
              is_flash <= !req_ram;
              polling  <= 1'b0;
              step     <= 3'd0;
              nsteps   <= req_erase ? 3'd6 : 3'd4;
              poll_addr <= i_addr;
              poll_prog <= (i_op == `FSP_OP_FL_PROG);
              poll_bit  <= i_wdata[7];
              cnt      <= 4'd0;
              state    <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          // One select only, never both.
          o_ram_bank_select_n   <= is_flash;
          o_flash_bank_select_n <= !is_flash;
          if (polling || op == `FSP_OP_RAM_RD || op == `FSP_OP_FL_RD) begin
            o_addr   <= polling ? poll_addr : addr;
            o_gate_n <= 1'b0;
            cnt      <= 4'd0;
            state    <= polling ? ST_POLL : ST_READ;
          end else begin
            o_gate_n <= 1'b1;
            o_addr   <= is_flash ? cmd_addr : addr;
            o_dq     <= is_flash ? cmd_data : wdata;
            o_dq_oe  <= 1'b1;
            if (cnt + 4'd1 >= SU_CYC[3:0]) begin
              cnt   <= 4'd0;
              state <= ST_WSTRB;
            end else begin
              cnt <= cnt + 4'd1;
            end
          end
        end
        ST_WSTRB: begin
          o_write_strobe_n <= 1'b0;
          if (cnt + 4'd1 >= WR_CYC[3:0]) begin
            cnt   <= 4'd0;
            state <= ST_WHOLD;
          end else begin
            cnt <= cnt + 4'd1;
          end
        end
        ST_WHOLD: begin
          // Strobe rises first; address and data held one more cycle.
          o_write_strobe_n <= 1'b1;
          o_ram_bank_select_n   <= 1'b1;
          o_flash_bank_select_n <= 1'b1;
          state <= ST_GAP;
          if (!is_flash || step + 3'd1 == nsteps) begin
            o_flash_busy <= o_flash_busy | is_flash;
            have_prev    <= 1'b0;
            o_done       <= 1'b1;
            o_busy       <= 1'b0;
          end else begin
            step <= step + 3'd1;
          end
        end
        ST_READ, ST_POLL: begin
          if (cnt + 4'd1 >= ACC_CYC[3:0]) begin
            o_gate_n              <= 1'b1;
            o_ram_bank_select_n   <= 1'b1;
            o_flash_bank_select_n <= 1'b1;
            cnt   <= 4'd0;
            state <= ST_GAP;
            if (state == ST_READ) begin
              o_rdata <= i_dq;
              o_done  <= 1'b1;
              o_busy  <= 1'b0;
            end else begin
              prev      <= i_dq;
              have_prev <= 1'b1;
              // Done when toggle bit is steady and DQ7 equals poll_bit (program) or is set (erase).
              if (have_prev && (prev[6] == i_dq[6]) &&
                  (!poll_prog || i_dq[7] == poll_bit) &&
                  (poll_prog || i_dq[7]))
                o_flash_busy <= 1'b0;
            end
          end else begin
            cnt <= cnt + 4'd1;
          end
        end
        ST_GAP: begin
          o_dq_oe <= 1'b0;
          polling <= 1'b0;
          cnt     <= 4'd0;
          state   <= (is_flash && o_busy) ? ST_SETUP : ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // fsp_host

// ==== verif/fsp_host_assertions.sv ====
`timescale 1ns/1ns
`include "fsp_regs.vh"
// ********************************
// Bus protocol checks on the pins
// ********************************
module fsp_host_chk #(parameter AW = 19, parameter DW = 8) (
  input wire          i_ref_clk,
  input wire          i_rst,
  input wire [AW-1:0] o_addr,
  input wire          o_write_strobe_n,
  input wire          o_gate_n,
  input wire          o_ram_bank_select_n,
  input wire          o_flash_bank_select_n,
  input wire [DW-1:0] o_dq,
  input wire          o_dq_oe
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_ONE_BANK: assert property (
    o_ram_bank_select_n || o_flash_bank_select_n)
    else $error("both bank selects low");
  AST_RAM_RANGE: assert property (!o_ram_bank_select_n |->
    o_addr < `FSP_RAM_LIMIT) else $error("ram select above ram region");
  AST_READ_GATE: assert property (!o_gate_n |->
    o_write_strobe_n && !o_dq_oe) else $error("gate low while writing");
  AST_CMD_LOAD: assert property (!o_write_strobe_n |->
    o_dq_oe && o_gate_n) else $error("strobe low without gate high");
  AST_WRITE_SEL: assert property (!o_write_strobe_n |->
    !(o_ram_bank_select_n && o_flash_bank_select_n))
    else $error("strobe low with no bank selected");
  AST_WRITE_WIDTH: assert property ($fell(o_write_strobe_n) |->
    !o_write_strobe_n [*5]) else $error("write pulse too short");
  AST_HOLD: assert property ($rose(o_write_strobe_n) |->
    $stable(o_addr) && $stable(o_dq) && o_dq_oe)
    else $error("address or data moved at strobe rise");
  AST_ADDR_SET: assert property ($fell(o_write_strobe_n) |->
    $stable(o_addr) && $past(o_dq_oe)) else $error("address not settled");
endmodule // fsp_host_chk
bind fsp_host fsp_host_chk #(.AW(AW), .DW(DW)) u_chk (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .o_addr(o_addr), .o_write_strobe_n(o_write_strobe_n),
  .o_gate_n(o_gate_n), .o_ram_bank_select_n(o_ram_bank_select_n),
  .o_flash_bank_select_n(o_flash_bank_select_n), .o_dq(o_dq),
  .o_dq_oe(o_dq_oe));

// ==== verif/fsp_dev_model.sv ====
`timescale 1ns/1ns
`include "fsp_regs.vh"
// ********************************
// Flash and RAM device model
// ********************************
module fsp_dev_model #(parameter ACC_NS = 60, parameter PROG_NS = 2000,
                       parameter ERASE_NS = 5000) (
  input  wire [18:0] i_addr,
  input  wire        i_write_strobe_n,
  input  wire        i_gate_n,
  input  wire        i_ram_bank_select_n,
  input  wire        i_flash_bank_select_n,
  input  wire [7:0]  i_dq,
  output wire [7:0]  o_dq
);
  reg  [7:0]  ram [0:131071];
  reg  [7:0]  fl [0:524287];
  reg  [18:0] cmd_addr;
  reg  [7:0]  last, pd;
  reg  [3:0]  step;
  reg         busy, erasing, tog;
  integer     dur, k;
  event       kick;
  wire fsel = !i_flash_bank_select_n;
  wire rsel = !i_ram_bank_select_n && !fsel;
  wire rd = (fsel || rsel) && !i_gate_n && i_write_strobe_n;
  wire rd_late;
  wire drive = rd && rd_late;
  wire fw = i_write_strobe_n || !fsel || !i_gate_n;
  wire rw = i_write_strobe_n || !rsel;
  wire ok1 = cmd_addr == `FSP_UNLOCK_A1 && i_dq == `FSP_UNLOCK_D1;
  wire ok2 = cmd_addr == `FSP_UNLOCK_A2 && i_dq == `FSP_UNLOCK_D2;
  wire [7:0] val = !fsel ? ram[i_addr[16:0]] : !busy ? fl[i_addr] :
                   {~pd[7] & ~erasing, tog, pd[5:0]};
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign #(ACC_NS) rd_late = rd;
  assign o_dq = drive ? val : ~last;
  always @* if (drive) last = val;
  initial begin
    for (k = 0; k < 524288; k = k + 1) fl[k] = 8'hFF;
    step = 0; busy = 0; tog = 0; last = 0; erasing = 0; pd = 0;
  end
  always @(posedge rw) ram[i_addr[16:0]] <= i_dq;
  always @(negedge fw) cmd_addr = i_addr;
  // Selects and gate move in one time step; look once they have settled.
  always @(negedge i_gate_n) #1 if (fsel && busy) tog = ~tog;
  always @(kick) begin
    #(dur);
    busy = 0;
  end
  always @(posedge fw) if (!busy) begin
    if (step == 4'd9) begin
      pd = i_dq;
      fl[cmd_addr] = fl[cmd_addr] & i_dq;
      erasing = 0; dur = PROG_NS; busy = 1; ->kick; step = 0;
    end else if (step == 4'd5 && (i_dq == `FSP_CMD_SECTOR ||
                                  i_dq == `FSP_CMD_BANK)) begin
      for (k = 0; k < 524288; k = k + 1)
        if (i_dq == `FSP_CMD_BANK || k[18:12] == cmd_addr[18:12])
          fl[k] = 8'hFF;
      erasing = 1; dur = ERASE_NS; busy = 1; ->kick; step = 0;
    end else case (step)
      0, 3: step = ok1 ? step + 4'd1 : 4'd0;
      1, 4: step = ok2 ? step + 4'd1 : 4'd0;
      2: step = cmd_addr != `FSP_UNLOCK_A1 ? 4'd0 :
                i_dq == `FSP_CMD_PROGRAM ? 4'd9 :
                i_dq == `FSP_CMD_ERASE ? 4'd3 : 4'd0;
      default: step = 0;
    endcase
  end
endmodule // fsp_dev_model

// ==== verif/fsp_host_bench.sv ====
`timescale 1ns/1ns
`include "fsp_regs.vh"
// ********************************
// Self-checking bench
// ********************************
module fsp_host_bench;
  reg         i_ref_clk = 0, i_rst = 1, i_req = 0;
  reg  [2:0]  i_op = 0;
  reg  [18:0] i_addr = 0;
  reg  [7:0]  i_wdata = 0, err;
  wire        o_busy, o_done, o_err, o_flash_busy, o_write_strobe_n;
  wire        o_gate_n, o_ram_bank_select_n, o_flash_bank_select_n, o_dq_oe;
  wire [7:0]  o_rdata, o_dq, dev_dq;
  wire [18:0] o_addr;
  wire [7:0]  bus = o_dq_oe ? o_dq : dev_dq;
  integer     fail_count = 0, n_tests = 0, cyc = 0, n;
  always #5 i_ref_clk = ~i_ref_clk;
  fsp_host dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(i_req),
    .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy),
    .o_done(o_done), .o_err(o_err), .o_rdata(o_rdata),
    .o_flash_busy(o_flash_busy), .o_addr(o_addr),
    .o_write_strobe_n(o_write_strobe_n), .o_gate_n(o_gate_n),
    .o_ram_bank_select_n(o_ram_bank_select_n),
    .o_flash_bank_select_n(o_flash_bank_select_n), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .i_dq(bus));
  fsp_dev_model u_dev (.i_addr(o_addr), .i_write_strobe_n(o_write_strobe_n),
    .i_gate_n(o_gate_n), .i_ram_bank_select_n(o_ram_bank_select_n),
    .i_flash_bank_select_n(o_flash_bank_select_n), .i_dq(bus),
    .o_dq(dev_dq));
  task final_report;
    begin
      $display("tests %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task req(input [2:0] op, input [18:0] a, input [7:0] d);
    begin
      @(posedge i_ref_clk) #1;
      i_req = 1; i_op = op; i_addr = a; i_wdata = d;
      err = 8'h00;
      n = 0;
      // The sequencer only looks in idle, so hold until taken or refused.
      while (n < 300 && o_busy !== 1'b1 && err == 8'h00) begin
        @(posedge i_ref_clk) #1;
        err = {7'h00, o_err};
        n = n + 1;
      end
      i_req = 0;
      while (n < 300 && o_done !== 1'b1 && err == 8'h00) begin
        @(posedge i_ref_clk) #1;
        n = n + 1;
      end
      if (n == 300) chk(8'h00, 8'h01);
    end
  endtask
  task wait_flash;
    begin
      for (n = 0; n < 3000 && o_flash_busy !== 1'b0; n = n + 1)
        @(posedge i_ref_clk) #1;
      chk({7'h00, o_flash_busy}, 8'h00);
    end
  endtask
  task t_ram;
    begin
      req(`FSP_OP_RAM_WR, 19'h0_0000, 8'hA5);
      req(`FSP_OP_RAM_WR, 19'h1_FFFF, 8'h3C);
      req(`FSP_OP_RAM_RD, 19'h0_0000, 8'h00);
      chk(o_rdata, 8'hA5);
      req(`FSP_OP_RAM_RD, 19'h1_FFFF, 8'h00);
      chk(o_rdata, 8'h3C);
      req(`FSP_OP_FL_RD, 19'h0_0000, 8'h00);
      chk(o_rdata, 8'hFF);
    end
  endtask
  task t_refuse;
    begin
      req(`FSP_OP_RAM_WR, 19'h2_0000, 8'h11);
      chk(err, 8'h01);
      req(3'h6, 19'h0_0000, 8'h00);
      chk(err, 8'h01);
    end
  endtask
  task t_flash;
    begin
      req(`FSP_OP_FL_PROG, 19'h1_2345, 8'h5A);
      chk(err, 8'h00);
      wait_flash;
      req(`FSP_OP_FL_PROG, 19'h1_3000, 8'h00);
      wait_flash;
      req(`FSP_OP_FL_RD, 19'h1_2345, 8'h00);
      chk(o_rdata, 8'h5A);
      req(`FSP_OP_FL_SECTOR, 19'h1_2345, 8'h00);
      req(`FSP_OP_FL_RD, 19'h1_2345, 8'h00);
      chk(err, 8'h01);
      req(`FSP_OP_RAM_WR, 19'h0_0100, 8'h77);
      req(`FSP_OP_RAM_RD, 19'h0_0100, 8'h00);
      chk(o_rdata, 8'h77);
      wait_flash;
      req(`FSP_OP_FL_RD, 19'h1_2345, 8'h00);
      chk(o_rdata, 8'hFF);
      req(`FSP_OP_FL_RD, 19'h1_3000, 8'h00);
      chk(o_rdata, 8'h00);
      req(`FSP_OP_FL_BANK, 19'h0_0000, 8'h00);
      wait_flash;
      req(`FSP_OP_FL_RD, 19'h1_3000, 8'h00);
      chk(o_rdata, 8'hFF);
    end
  endtask
  always @(posedge i_ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge i_ref_clk);
    #1 i_rst = 0;
    t_ram;
    t_refuse;
    t_flash;
    final_report;
  end
endmodule // fsp_host_bench
